// ===== design/swc_pkg.sv
// Purpose: Shared constants and types of the sleep and wake controller.
// Assumes: One 50 MHz clock; registers reached over classic Wishbone.
// Notes:   The oscillator period equals the clock period of this model.
//
// How it works
// [R1] Sleep instruction clears the watchdog counter and, if enabled, its postscaler.
// [R2] Sleep entry clears the power-down flag and sets the time-out flag.
// [R3] The oscillator driver is off while asleep.
// [R4] Ports hold their previous drive state while asleep.
// [R5] Watchdog reset stays internal and never drives the master clear pin.
// [R6] Resets, enabled watchdog, pins and listed peripheral interrupts end sleep.
// [R7] Only capture, serial, converter, peripheral-bus and two-wire slave interrupts wake.
// [R8] Peripherals that need phase clocks raise no interrupt while asleep.
// [R9] Reset wakes give a full reset; interrupt wakes resume the program.
// [R10] Power-down flag is set at power-up and cleared by the sleep instruction.
// [R11] Time-out flag clears when a watchdog time-out causes a reset.
// [R12] The next program address is prefetched while the sleep instruction executes.
// [R13] A source wakes only with its enable set, whatever the global disable.
// [R14] After a wake, run the prefetched instruction, then vector if enabled.
// [R15] Sleep with an enabled pending flag wakes at once, same flag update.
// [R16] Every wake-up clears the watchdog counter.
// [R17] Crystal or low-frequency mode holds the device for 1024 oscillator periods.
// [R18] Resistor-capacitor mode wakes with no start-up delay.
// [R19] Wake request is OR of flag-and-enable pairs plus any reset request.
package swc_pkg;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam int          WB_ADR_W     = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_INT_EN   = 8'h08;
    localparam logic [7:0]  OFS_INT_FLAG = 8'h0C;
    localparam logic [7:0]  OFS_EVT      = 8'h10;
    localparam logic [7:0]  OFS_EVT_MASK = 8'h14;

    localparam int          CTRL_W       = 5;
    localparam int          CTRL_OSC_LSB = 0;
    localparam int          CTRL_GDIS    = 2;
    localparam int          CTRL_WDT_EN  = 3;
    localparam int          CTRL_PS_EN   = 4;
    localparam logic [4:0]  CTRL_RESET   = 5'h04;

    localparam int          STAT_PD      = 0;
    localparam int          STAT_TO      = 1;
    localparam int          STAT_ASLEEP  = 2;
    localparam int          STAT_OST     = 3;

    // ----------------------------------------------------------------------
    // Interrupt sources and events
    // ----------------------------------------------------------------------
    localparam int          PIN_N        = 6;
    localparam int          PIN_EXT      = 0;
    localparam int          PIN_PORTB    = 1;
    localparam int          PIN_T0       = 2;
    localparam int          PIN_MCLR_N   = 3;
    localparam int          PIN_POR      = 4;
    localparam int          PIN_BOR      = 5;
    localparam int          PERIPH_N     = 7;
    localparam int          SRC_N        = 10;
    localparam int          SRC_CLOCKED  = 9;
    localparam logic [9:0]  WAKE_CAPABLE = 10'h1FF;
    localparam logic [9:0]  SRC_RESET    = 10'h000;
    localparam int          EVT_N        = 4;
    localparam int          EVT_SLEEP    = 0;
    localparam int          EVT_WAKE_INT = 1;
    localparam int          EVT_WAKE_RST = 2;
    localparam int          EVT_WDT_RST  = 3;
    localparam logic [3:0]  EVT_RESET    = 4'h0;

    // ----------------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          OSC_PERIOD_NS = 20;
    localparam int          OST_TOSC      = 1024;
    localparam int          OST_TIME_NS   = OST_TOSC * OSC_PERIOD_NS;
    localparam int          OST_CYCLES    = (OST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        SWC_OSC_RC        = 2'h0,
        SWC_OSC_CRYSTAL   = 2'h1,
        SWC_OSC_LOW_FREQ  = 2'h2,
        SWC_OSC_EXTERNAL  = 2'h3
    } swc_osc_type;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_OST
    } swc_state_type;

endpackage

// ===== design/swc_ost_if.sv
// Purpose: Start and completion signals of the oscillator start-up timer.
// Assumes: Same clock on both ends.
// Notes:   Done is a one-cycle pulse in the last counted cycle.
`timescale 1ns/1ps
interface swc_ost_if;
    logic start;
    logic busy;
    logic done;
    modport ctrl  (output start, input busy, input done);
    modport timer (input start, output busy, output done);
endinterface

// ===== design/swc_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pin levels.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/1ps
module swc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    input  wire logic [W-1:0] init_i,
    output logic      [W-1:0] q_o
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : g_bit
            logic meta_reg;
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    meta_reg <= init_i[g];
                    q_o[g]   <= init_i[g];
                end
                else
                begin
                    meta_reg <= d_i[g];
                    q_o[g]   <= meta_reg;
                end
            end
        end
    endgenerate
endmodule

// ===== design/swc_ost.sv
// Purpose: Oscillator start-up timer counting a fixed number of cycles.
// Assumes: Start is a single-cycle request while idle.
// Notes:   A start while busy is ignored.
`timescale 1ns/1ps
module swc_ost #(
    parameter int CYCLES = swc_pkg::OST_CYCLES
) (
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    swc_ost_if.timer    ost
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_reg;
    logic          busy_reg;
    wire           last = busy_reg && (cnt_reg == CW'(CYCLES - 1));

    assign ost.busy = busy_reg;
    assign ost.done = last;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || last)
        begin
            busy_reg <= 1'b0;
            cnt_reg  <= '0;
        end
        else if (busy_reg)
            cnt_reg  <= cnt_reg + 1'b1;
        else if (ost.start)
            busy_reg <= 1'b1;
    end
endmodule

// ===== design/swc_top.sv
// Purpose: Sleep entry, wake-up decision and start-up delay for the core.
// Assumes: Core, watchdog and peripheral signals are on clk_i; pins are not.
// Notes:   Registers sit on a classic Wishbone slave with a one-cycle ack.
//
// Register access over Wishbone and the register addresses were decided locally.
`timescale 1ns/1ps
module swc_top #(
    parameter int OST_CYCLES_P = swc_pkg::OST_CYCLES
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [swc_pkg::WB_ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    output logic                                irq_o,
    input  wire logic                           sleep_exec_i,
    input  wire logic [15:0]                    pc_i,
    input  wire logic                           wdt_timeout_i,
    input  wire logic                           external_int_pin_i,
    input  wire logic                           portb_change_i,
    input  wire logic                           timer0_clock_input_i,
    input  wire logic                           master_clear_pin_n_i,
    input  wire logic                           por_i,
    input  wire logic                           bor_i,
    input  wire logic [swc_pkg::PERIPH_N-1:0]   periph_int_i,
    output logic                                master_clear_pin_o,
    output logic                                master_clear_pin_oe_o,
    output logic                                wdt_clear_o,
    output logic                                postscaler_clear_o,
    output logic                                osc_drive_en_o,
    output logic                                port_hold_o,
    output logic                                core_hold_o,
    output logic                                core_reset_o,
    output logic                                resume_o,
    output logic                                vector_o,
    output logic      [15:0]                    prefetch_addr_o
);
    import swc_pkg::*;

    // ----------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------------
    logic [PIN_N-1:0]  pin_s;
    logic [PIN_N-1:0]  pin_prev_reg;
    wire  [PIN_N-1:0]  pin_raw = {bor_i, por_i, master_clear_pin_n_i,
                                  timer0_clock_input_i, portb_change_i, external_int_pin_i};

    swc_sync #(.W(PIN_N)) u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .d_i    (pin_raw),
        .init_i ('0),
        .q_o    (pin_s)
    );

    wire ext_edge   = pin_s[PIN_EXT] && !pin_prev_reg[PIN_EXT];
    wire portb_edge = pin_s[PIN_PORTB] != pin_prev_reg[PIN_PORTB];
    wire t0_edge    = pin_s[PIN_T0] && !pin_prev_reg[PIN_T0];
    // The synchroniser clears to zero, so hold off the low master clear until it has filled.
    logic [1:0] fill_reg;
    wire  pins_ok   = fill_reg[1];
    wire  mclr_req  = pins_ok && !pin_s[PIN_MCLR_N];
    wire  pwr_req   = pin_s[PIN_POR] || pin_s[PIN_BOR];

    // ----------------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_reg;
    logic [SRC_N-1:0]  int_en_reg;
    logic [SRC_N-1:0]  int_flag_reg;
    logic [EVT_N-1:0]  evt_reg;
    logic [EVT_N-1:0]  evt_mask_reg;
    logic              pd_reg;
    logic              to_reg;
    logic              cause_reg;
    swc_state_type     state_reg;
    swc_state_type     state_next;
    swc_ost_if         ost_bus ();

    swc_ost #(.CYCLES(OST_CYCLES_P)) u_ost (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ost   (ost_bus.timer)
    );

    swc_osc_type osc_mode;
    assign osc_mode  = swc_osc_type'(ctrl_reg[CTRL_OSC_LSB +: 2]);
    wire gdis        = ctrl_reg[CTRL_GDIS];
    wire wdt_en      = ctrl_reg[CTRL_WDT_EN];
    wire ps_en       = ctrl_reg[CTRL_PS_EN];
    wire need_ost    = (osc_mode == SWC_OSC_CRYSTAL) || (osc_mode == SWC_OSC_LOW_FREQ); // [R17] [R18]
    wire in_run      = state_reg == ST_RUN;
    wire in_sleep    = state_reg == ST_SLEEP;
    wire in_ost      = state_reg == ST_OST;

    // ----------------------------------------------------------------------
    // Wake decision
    // ----------------------------------------------------------------------
    wire wdt_rst     = wdt_timeout_i && wdt_en && !in_ost; // [R6]
    wire reset_req   = pwr_req || mclr_req || wdt_rst; // [R6]
    // Only enabled, wake-capable flags count; the global disable is not looked at.
    wire int_pending = |(int_flag_reg & int_en_reg & WAKE_CAPABLE); // [R7] [R13] [R19]
    wire wake_req    = int_pending || reset_req; // [R19]
    wire sleep_go    = in_run && sleep_exec_i && !reset_req && !int_pending;
    wire sleep_now   = in_run && sleep_exec_i && !reset_req && int_pending; // [R15]
    wire sleep_acc   = sleep_go || sleep_now;
    wire wake_now    = in_sleep && wake_req;
    wire cause_now   = in_sleep ? reset_req : cause_reg;
    wire wake_done   = (wake_now && !need_ost) || (in_ost && ost_bus.done);
    wire run_reset   = in_run && reset_req;
    wire resume_next = (wake_done && !cause_now) || sleep_now; // [R9] [R14]
    wire rst_next    = run_reset || (wake_now && reset_req) || (in_ost && cause_reg); // [R9] [R17]

    assign ost_bus.start = wake_now && need_ost; // [R17]

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN:
                if (sleep_go)
                    state_next = ST_SLEEP;
            ST_SLEEP:
                if (wake_req)
                    state_next = need_ost ? ST_OST : ST_RUN; // [R17] [R18]
            ST_OST:
                if (ost_bus.done)
                    state_next = ST_RUN;
        endcase
    end

    // ----------------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------------
    wire pd_next = pwr_req ? 1'b1 : (sleep_acc ? 1'b0 : pd_reg); // [R2] [R10] [R15]
    wire to_next = pwr_req ? 1'b1 : (wdt_rst ? 1'b0 : (sleep_acc ? 1'b1 : to_reg)); // [R2] [R11]

    // The clocked-peripheral source cannot flag while its phase clocks are stopped.
    wire [SRC_N-1:0] src_set = {periph_int_i[PERIPH_N-1] && !in_sleep, // [R8]
                                periph_int_i[PERIPH_N-2:0], t0_edge, portb_edge, ext_edge};
    wire [EVT_N-1:0] evt_set;
    assign evt_set[EVT_SLEEP]    = sleep_go;
    assign evt_set[EVT_WAKE_INT] = resume_next;
    assign evt_set[EVT_WAKE_RST] = wake_now && reset_req;
    assign evt_set[EVT_WDT_RST]  = wdt_rst;

    // ----------------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------------
    wire        wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wb_wr   = wb_req && wb_we_i;
    wire [31:0] bm      = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [31:0] wmask   = wb_dat_i & bm;
    wire        hit_ctl = wb_adr_i == OFS_CTRL;
    wire        hit_sta = wb_adr_i == OFS_STATUS;
    wire        hit_ien = wb_adr_i == OFS_INT_EN;
    wire        hit_ifl = wb_adr_i == OFS_INT_FLAG;
    wire        hit_evt = wb_adr_i == OFS_EVT;
    wire        hit_msk = wb_adr_i == OFS_EVT_MASK;
    wire [31:0] ctl_mrg = ({{(32 - CTRL_W){1'b0}}, ctrl_reg} & ~bm) | wmask;
    wire [31:0] ien_mrg = ({{(32 - SRC_N){1'b0}}, int_en_reg} & ~bm) | wmask;
    wire [31:0] msk_mrg = ({{(32 - EVT_N){1'b0}}, evt_mask_reg} & ~bm) | wmask;
    wire [31:0] stat_rd = {{(32 - 4){1'b0}}, ost_bus.busy, in_sleep, to_reg, pd_reg};
    // Unmapped offsets acknowledge and read as zero.
    wire [31:0] rd_data = hit_ctl ? {{(32 - CTRL_W){1'b0}}, ctrl_reg} :
                          hit_sta ? stat_rd :
                          hit_ien ? {{(32 - SRC_N){1'b0}}, int_en_reg} :
                          hit_ifl ? {{(32 - SRC_N){1'b0}}, int_flag_reg} :
                          hit_evt ? {{(32 - EVT_N){1'b0}}, evt_reg} :
                          hit_msk ? {{(32 - EVT_N){1'b0}}, evt_mask_reg} : 32'h0000_0000;
    // Set beats clear, so an event in the write-one-to-clear cycle survives.
    wire [SRC_N-1:0] ifl_clr  = (wb_wr && hit_ifl) ? wmask[SRC_N-1:0] : '0;
    wire [EVT_N-1:0] evt_clr  = (wb_wr && hit_evt) ? wmask[EVT_N-1:0] : '0;

    // ----------------------------------------------------------------------
    // Sequential logic
    // ----------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o     <= 1'b0;
            wb_dat_o     <= 32'h0000_0000;
            ctrl_reg     <= CTRL_RESET;
            int_en_reg   <= SRC_RESET;
            int_flag_reg <= SRC_RESET;
            evt_reg      <= EVT_RESET;
            evt_mask_reg <= EVT_RESET;
            irq_o        <= 1'b0;
            pin_prev_reg <= '0;
            fill_reg     <= 2'h0;
        end
        else
        begin
            wb_ack_o     <= wb_req;
            wb_dat_o     <= wb_req ? rd_data : 32'h0000_0000;
            ctrl_reg     <= (wb_wr && hit_ctl) ? ctl_mrg[CTRL_W-1:0] : ctrl_reg;
            int_en_reg   <= (wb_wr && hit_ien) ? ien_mrg[SRC_N-1:0] : int_en_reg;
            evt_mask_reg <= (wb_wr && hit_msk) ? msk_mrg[EVT_N-1:0] : evt_mask_reg;
            int_flag_reg <= (int_flag_reg & ~ifl_clr) | src_set;
            evt_reg      <= (evt_reg & ~evt_clr) | evt_set;
            irq_o        <= |(((evt_reg & ~evt_clr) | evt_set) & evt_mask_reg);
            pin_prev_reg <= pin_s;
            fill_reg     <= {fill_reg[0], 1'b1};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg          <= ST_RUN;
            pd_reg             <= 1'b1; // [R10]
            to_reg             <= 1'b1;
            cause_reg          <= 1'b0;
            wdt_clear_o        <= 1'b0;
            postscaler_clear_o <= 1'b0;
            osc_drive_en_o     <= 1'b1;
            port_hold_o        <= 1'b0;
            core_hold_o        <= 1'b0;
            core_reset_o       <= 1'b0;
            resume_o           <= 1'b0;
            vector_o           <= 1'b0;
            prefetch_addr_o    <= 16'h0000;
            master_clear_pin_o    <= 1'b0;
            master_clear_pin_oe_o <= 1'b0;
        end
        else
        begin
            state_reg          <= state_next;
            pd_reg             <= pd_next;
            to_reg             <= to_next;
            cause_reg          <= wake_now ? reset_req : cause_reg;
            wdt_clear_o        <= sleep_acc || wake_now; // [R1] [R16]
            postscaler_clear_o <= sleep_acc && ps_en; // [R1]
            osc_drive_en_o     <= state_next != ST_SLEEP; // [R3]
            port_hold_o        <= state_next == ST_SLEEP; // [R4]
            core_hold_o        <= state_next != ST_RUN;
            core_reset_o       <= rst_next;
            resume_o           <= resume_next;
            vector_o           <= resume_next ? !gdis : vector_o; // [R14]
            prefetch_addr_o    <= sleep_acc ? pc_i + 16'h0001 : prefetch_addr_o; // [R12]
            // The pin is an input only; no reset source drives it.
            master_clear_pin_o    <= 1'b0; // [R5]
            master_clear_pin_oe_o <= 1'b0; // [R5]
        end
    end

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    localparam int OLW = $clog2(OST_CYCLES_P + 2);
    logic [OLW-1:0] ost_len_reg;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !in_ost)
            ost_len_reg <= '0;
        else
            ost_len_reg <= ost_len_reg + 1'b1;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_sleep_entry;
        sleep_go;
    endsequence
    sequence s_rc_reset_wake;
        wake_now && reset_req && !need_ost;
    endsequence
    sequence s_ost_exit;
        $past(state_reg) == ST_OST && state_reg == ST_RUN;
    endsequence

    property p_entry_clears;
        s_sleep_entry |=> wdt_clear_o && !pd_reg && to_reg && in_sleep;
    endproperty
    a_entry_clears: assert property (p_entry_clears) else $error("sleep entry flags wrong"); // [R1] [R2]
    property p_osc_off;
        s_sleep_entry |=> !osc_drive_en_o && port_hold_o && core_hold_o;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator or ports not frozen"); // [R3] [R4]
    property p_mclr_quiet;
        wdt_rst |=> !master_clear_pin_oe_o [*2];
    endproperty
    a_mclr_quiet: assert property (p_mclr_quiet) else $error("master clear driven"); // [R5]
    property p_ost_len;
        s_ost_exit |-> ost_len_reg == OLW'(OST_CYCLES_P) && core_hold_o == 1'b0 ##0 !osc_drive_en_o == 1'b0;
    endproperty
    a_ost_len: assert property (p_ost_len) else $error("start-up delay length wrong"); // [R17]
    property p_rc_fast;
        wake_now && !need_ost |=> in_run && wdt_clear_o;
    endproperty
    a_rc_fast: assert property (p_rc_fast) else $error("resistor mode wake delayed"); // [R18] [R16]
    property p_reset_wake;
        s_rc_reset_wake |=> core_reset_o && !resume_o ##1 !core_reset_o;
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("reset wake not a reset pulse"); // [R9]
    property p_wake_any_gdis;
        in_sleep && int_pending && !reset_req |=> !in_sleep;
    endproperty
    a_wake_any_gdis: assert property (p_wake_any_gdis) else $error("enabled flag did not wake"); // [R13] [R19]
    property p_immediate;
        sleep_now |=> resume_o && in_run && !pd_reg && to_reg && vector_o == !$past(gdis);
    endproperty
    a_immediate: assert property (p_immediate) else $error("pending flag did not wake at once"); // [R15] [R14]
    property p_no_clocked_flag;
        in_sleep && !int_flag_reg[SRC_CLOCKED] |=> !int_flag_reg[SRC_CLOCKED];
    endproperty
    a_no_clocked_flag: assert property (p_no_clocked_flag) else $error("clocked source flagged in sleep"); // [R8]
    property p_to_wdt;
        wdt_rst && !pwr_req |=> !to_reg;
    endproperty
    a_to_wdt: assert property (p_to_wdt) else $error("time-out flag not cleared"); // [R11]
    property p_power_flags;
        pwr_req |=> pd_reg && to_reg;
    endproperty
    a_power_flags: assert property (p_power_flags) else $error("power-up flags wrong"); // [R10]
    property p_prefetch;
        sleep_acc |=> prefetch_addr_o == $past(pc_i) + 16'h0001;
    endproperty
    a_prefetch: assert property (p_prefetch) else $error("prefetch address wrong"); // [R12]
    property p_no_wake_idle;
        in_sleep && !wake_req |=> in_sleep;
    endproperty
    a_no_wake_idle: assert property (p_no_wake_idle) else $error("woke with no cause"); // [R6] [R7]

endmodule

// ===== tb/swc_core_model.sv
// Purpose: Core model that issues the sleep instruction and counts resumes.
// Assumes: Same clock as the controller.
// Notes:   The sleep pulse lasts one cycle per request.
`timescale 1ns/1ps
module swc_core_model (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic        resume_i,
    output logic             sleep_exec_o,
    output logic [15:0]      pc_o,
    output int               resumes_o
);
    initial
    begin
        sleep_exec_o = 1'b0;
        pc_o = 16'h0100;
        resumes_o = 0;
    end
    always @(posedge clk_i)
    begin
        sleep_exec_o <= go_i;
        if (resume_i)
            resumes_o <= resumes_o + 1;
    end
endmodule

// ===== tb/testbench.sv
// Purpose: Self-checking bench of the sleep and wake controller.
// Assumes: Start-up delay shortened to 8 cycles.
// Notes:   Inputs change by non-blocking assignment after a rising edge.
`timescale 1ns/1ps
module testbench;
    import swc_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc = 0, we = 0, go = 0, ext = 0, wdt = 0, pb = 0, por = 0;
    logic [6:0]  pi = 7'h00;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q;
    logic        ack, irq, moe, wclr, pclr, osc, phold, res, vec, sx, mpin, chold, crst;
    logic [15:0] pc, pfa;
    int          err_total = 0, checks = 0, resumes, n;
    initial forever #10 clk_i = ~clk_i;
    swc_top #(.OST_CYCLES_P(8)) i_swc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .sleep_exec_i(sx), .pc_i(pc), .wdt_timeout_i(wdt), .external_int_pin_i(ext),
        .portb_change_i(pb), .timer0_clock_input_i(1'b0), .master_clear_pin_n_i(1'b1), .por_i(por),
        .bor_i(1'b0), .periph_int_i(pi), .master_clear_pin_o(mpin), .master_clear_pin_oe_o(moe),
        .wdt_clear_o(wclr), .postscaler_clear_o(pclr), .osc_drive_en_o(osc), .port_hold_o(phold),
        .core_hold_o(chold), .core_reset_o(crst), .resume_o(res), .vector_o(vec), .prefetch_addr_o(pfa));
    swc_core_model i_swc_core_model (.clk_i(clk_i), .go_i(go), .resume_i(res), .sleep_exec_o(sx),
        .pc_o(pc), .resumes_o(resumes));
    task automatic stop_test;
        $display("err_total=%0d checks=%0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && ++k < 50);
        q = rdat;
        if (ack !== 1'b1)
            chk(1'b0, 1'b1);
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic slp;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    initial
    begin
        repeat (3000) @(posedge clk_i);
        err_total++;
        stop_test();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, OFS_STATUS, 0); chk(q, 32'h3);
        wb(0, OFS_CTRL, 0); chk(q, 32'h4);
        wb(0, 8'h40, 0); chk(q, 32'h0);
        wb(1, OFS_CTRL, 32'h19);
        wb(1, OFS_INT_EN, 32'h1);
        wb(1, OFS_EVT_MASK, 32'h1);
        slp(); chk({wclr, pclr}, 2'b11);
        chk(pfa, 16'h0101);
        repeat (2) @(posedge clk_i);
        chk({osc, phold, chold}, 3'b011);
        wb(0, OFS_STATUS, 0); chk(q, 32'h6);
        chk(irq, 1'b1);
        ext <= 1'b1;
        for (n = 0; n < 200 && resumes == 0; n++) @(posedge clk_i);
        chk(n, 14);
        chk(vec, 1'b1);
        wb(0, OFS_STATUS, 0); chk(q, 32'h2);
        slp(); repeat (2) @(posedge clk_i);
        chk(resumes, 2);
        chk(osc, 1'b1);
        wb(1, OFS_EVT, 32'hF);
        wb(1, OFS_EVT_MASK, 32'h0); chk(irq, 1'b0);
        wdt <= 1'b1;
        @(posedge clk_i);
        wdt <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({mpin, moe}, 2'b00);
        wb(0, OFS_STATUS, 0); chk(q, 32'h0);
        wb(1, OFS_CTRL, 32'h08);
        wb(1, OFS_INT_FLAG, 32'h3FF);
        wb(1, OFS_INT_EN, 32'h8);
        slp();
        pi <= 7'h40;
        pb <= 1'b1;
        @(posedge clk_i);
        wb(0, OFS_INT_FLAG, 0); chk(q, 32'h0);
        pi <= 7'h41;
        @(posedge clk_i);
        pi <= 7'h00;
        repeat (2) @(posedge clk_i);
        chk({res, wclr}, 2'b11);
        wb(0, OFS_INT_FLAG, 0); chk(q, 32'h00A);
        wb(1, OFS_INT_FLAG, 32'h3FF);
        slp();
        wdt <= 1'b1;
        @(posedge clk_i);
        wdt <= 1'b0;
        @(posedge clk_i);
        chk({crst, res, chold}, 3'b100);
        por <= 1'b1;
        @(posedge clk_i);
        por <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(0, OFS_STATUS, 0); chk(q, 32'h3);
        stop_test();
    end
endmodule
